/* mode_entry_pkg.sv */
package mode_entry_pkg;
   // register offsets (byte addresses, one word each)
   localparam logic [7:0] MODE_REQ_OFS = 8'h00;
   localparam logic [7:0] GLOBAL_STATUS_OFS = 8'h04;
   localparam logic [7:0] RUN_CFG_OFS = 8'h08;
   localparam logic [7:0] STOP_CFG_OFS = 8'h18;
   localparam logic [7:0] HALT_CFG_OFS = 8'h1C;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
   localparam logic [7:0] IRQ_CLEAR_OFS = 8'h24;
   localparam logic [7:0] IRQ_ENABLE_OFS = 8'h28;
   // flash power configuration codes
   localparam logic [1:0] FLASH_POWER_DOWN = 2'h1;
   localparam logic [1:0] FLASH_LOW_POWER = 2'h2;
   localparam logic [1:0] FLASH_NORMAL = 2'h3;
   localparam logic [1:0] FLASH_CFG_RESET = 2'h3;
   // mode codes
   localparam logic [2:0] MODE_RUN0 = 3'h0;
   localparam logic [2:0] MODE_STOP = 3'h4;
   localparam logic [2:0] MODE_HALT = 3'h5;
   localparam int RUN_MODES = 4;
   // global status field positions
   localparam int GS_MODE_LSB = 0;
   localparam int GS_FLASH_LSB = 4;
   localparam int GS_MTRANS_BIT = 8;
   localparam int GS_RAM_EXEC_BIT = 9;
   // interrupt event bits
   localparam int IRQ_BITS = 3;
   localparam int EV_DONE = 0;
   localparam int EV_MCHK = 1;
   localparam int EV_WAKE = 2;
   localparam logic [IRQ_BITS-1:0] IRQ_RESET = 3'h0;
   // timing
   localparam int HAZARD_CYCLES = 4;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int FLASH_SETTLE_NS = 40;
   localparam int FLASH_SETTLE_CYC =
      (FLASH_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_LP_ENTRY = 4'h2,
      ST_LP = 4'h4,
      ST_TRANS = 4'h8
   } me_state_t;
endpackage

/* flash_ctrl_if.sv */
`timescale 1ns/10ps
interface flash_ctrl_if;
   logic start;
   logic [1:0] target;
   logic busy;
   logic [1:0] power;
   modport ctrl (output start, output target, input busy, input power);
   modport flash (input start, input target, output busy, output power);
endinterface

/* flash_power_ctl.sv */
`timescale 1ns/10ps
module flash_power_ctl #(
   parameter int SETTLE_CYC = mode_entry_pkg::FLASH_SETTLE_CYC
) (
   input wire logic core_clk,
   input wire logic arst_n,
   flash_ctrl_if.flash fl
);
   logic [7:0] cnt_q, cnt_d;
   logic busy_q, busy_d;
   logic [1:0] tgt_q, tgt_d;
   logic [1:0] power_q, power_d;

   // power state only changes once settle time has passed
   always_comb begin
      cnt_d = cnt_q;
      busy_d = busy_q;
      tgt_d = tgt_q;
      power_d = power_q;
      if (fl.start) begin
         tgt_d = fl.target;
         busy_d = 1'b1;
         cnt_d = 8'(SETTLE_CYC - 1);
      end else if (busy_q) begin
         if (cnt_q == 8'h00) begin
            busy_d = 1'b0;
            power_d = tgt_q;
         end else begin
            cnt_d = cnt_q - 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 8'h00;
         busy_q <= 1'b0;
         tgt_q <= mode_entry_pkg::FLASH_CFG_RESET;
         power_q <= mode_entry_pkg::FLASH_CFG_RESET;
      end else begin
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         tgt_q <= tgt_d;
         power_q <= power_d;
      end
   end

   assign fl.busy = busy_q;
   assign fl.power = power_q;
endmodule

/* mode_entry_unit.sv */
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module mode_entry_unit (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   input wire logic wakeup,
   input wire logic code_in_flash,
   input wire logic core_machine_check_enable,
   output logic machine_check_irq,
   output logic checkstop_reset,
   output logic exec_from_ram,
   output logic irq
);
   flash_ctrl_if fl ();

   flash_power_ctl u_flash (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .fl(fl)
   );

   ////////////////////////////////////////////////////////////////////////
   // registers and state
   mode_entry_pkg::me_state_t st_q, st_d;
   logic [1:0] run_cfg_q [mode_entry_pkg::RUN_MODES];
   logic [1:0] run_cfg_d [mode_entry_pkg::RUN_MODES];
   logic [1:0] stop_cfg_q, stop_cfg_d, halt_cfg_q, halt_cfg_d;
   logic [2:0] mode_q, mode_d, run_q, run_d;
   logic [1:0] haz_q, haz_d;
   logic mtrans_q, mtrans_d;
   logic [1:0] lp_cfg_q, lp_cfg_d;
   logic [mode_entry_pkg::IRQ_BITS-1:0] ist_q, ist_d, ien_q, ien_d;
   logic [mode_entry_pkg::IRQ_BITS-1:0] ev;
   logic mchk_irq_q, mchk_irq_d, chkstop_q, chkstop_d;
   logic ram_q, ram_d, irq_q, irq_d;
   logic [31:0] rdata_q, rdata_d;
   logic fl_start;
   logic [1:0] fl_target;
   logic req, req_run, req_lp;
   logic fl_start_q;

   assign req = wr_stb && addr == mode_entry_pkg::MODE_REQ_OFS;
   assign req_run = req && wdata[2] == 1'b0;
   assign req_lp = req && (wdata[2:0] == mode_entry_pkg::MODE_STOP ||
                           wdata[2:0] == mode_entry_pkg::MODE_HALT);

   ////////////////////////////////////////////////////////////////////////
   // mode sequencer
   always_comb begin
      st_d = st_q;
      mode_d = mode_q;
      run_d = run_q;
      haz_d = haz_q;
      mtrans_d = mtrans_q;
      lp_cfg_d = lp_cfg_q;
      fl_start = 1'b0;
      fl_target = run_cfg_q[run_q[1:0]];
      ev = '0;
      mchk_irq_d = 1'b0;
      chkstop_d = 1'b0;
      unique case (st_q)
         mode_entry_pkg::ST_RUN: begin
            if (req_run) begin
               // same run mode is re-entered too, so new config applies
               run_d = wdata[2:0];
               mode_d = wdata[2:0];
               fl_start = 1'b1;
               fl_target = run_cfg_q[wdata[1:0]];
               mtrans_d = 1'b1;
               st_d = mode_entry_pkg::ST_TRANS;
            end else if (req_lp) begin
               mode_d = wdata[2:0];
               lp_cfg_d = (wdata[2:0] == mode_entry_pkg::MODE_STOP) ?
                          stop_cfg_q : halt_cfg_q;
               haz_d = 2'h0;
               mtrans_d = 1'b1;
               st_d = mode_entry_pkg::ST_LP_ENTRY;
            end
         end
         mode_entry_pkg::ST_LP_ENTRY: begin
            haz_d = haz_q + 2'h1;
            if (wakeup) begin
               // flash already committed to going down; run mode
               // is re-entered believing it is still available
               ev[mode_entry_pkg::EV_WAKE] = 1'b1;
               mode_d = run_q;
               fl_start = 1'b1;
               fl_target = lp_cfg_q;
               st_d = mode_entry_pkg::ST_TRANS;
               if (code_in_flash &&
                   lp_cfg_q != mode_entry_pkg::FLASH_NORMAL) begin
                  ev[mode_entry_pkg::EV_MCHK] = 1'b1;
                  mchk_irq_d = core_machine_check_enable;
                  chkstop_d = !core_machine_check_enable;
               end
            end else if (haz_q == 2'(mode_entry_pkg::HAZARD_CYCLES - 1)) begin
               fl_start = 1'b1;
               fl_target = lp_cfg_q;
               st_d = mode_entry_pkg::ST_LP;
            end
         end
         mode_entry_pkg::ST_LP: begin
            if (!fl.busy) begin
               mtrans_d = 1'b0;
            end
            if (wakeup && !fl.busy) begin
               ev[mode_entry_pkg::EV_WAKE] = 1'b1;
               mode_d = run_q;
               fl_start = 1'b1;
               fl_target = run_cfg_q[run_q[1:0]];
               mtrans_d = 1'b1;
               st_d = mode_entry_pkg::ST_TRANS;
            end
         end
         mode_entry_pkg::ST_TRANS: begin
            if (!fl.busy && !fl_start_q) begin
               mtrans_d = 1'b0;
               ev[mode_entry_pkg::EV_DONE] = 1'b1;
               st_d = mode_entry_pkg::ST_RUN;
            end
         end
         default: begin
            st_d = mode_entry_pkg::ST_RUN;
            mtrans_d = 1'b0;
         end
      endcase
   end

   // busy from the flash lags start by one cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fl_start_q <= 1'b0;
      end else begin
         fl_start_q <= fl_start;
      end
   end

   assign fl.start = fl_start;
   assign fl.target = fl_target;

   ////////////////////////////////////////////////////////////////////////
   // register file and interrupts
   always_comb begin
      run_cfg_d = run_cfg_q;
      stop_cfg_d = stop_cfg_q;
      halt_cfg_d = halt_cfg_q;
      ien_d = ien_q;
      ist_d = ist_q;
      rdata_d = 32'h0000_0000;
      if (wr_stb) begin
         for (int i = 0; i < mode_entry_pkg::RUN_MODES; i++) begin
            if (addr == 8'(mode_entry_pkg::RUN_CFG_OFS + 4 * i)) begin
               run_cfg_d[i] = wdata[1:0];
            end
         end
         if (addr == mode_entry_pkg::STOP_CFG_OFS) begin
            stop_cfg_d = wdata[1:0];
         end
         if (addr == mode_entry_pkg::HALT_CFG_OFS) begin
            halt_cfg_d = wdata[1:0];
         end
         if (addr == mode_entry_pkg::IRQ_ENABLE_OFS) begin
            ien_d = wdata[mode_entry_pkg::IRQ_BITS-1:0];
         end
         if (addr == mode_entry_pkg::IRQ_CLEAR_OFS) begin
            ist_d = ist_q & ~wdata[mode_entry_pkg::IRQ_BITS-1:0];
         end
      end
      // set wins over a clear in the same cycle
      ist_d = ist_d | ev;
      if (rd_stb) begin
         for (int i = 0; i < mode_entry_pkg::RUN_MODES; i++) begin
            if (addr == 8'(mode_entry_pkg::RUN_CFG_OFS + 4 * i)) begin
               rdata_d = {30'h0, run_cfg_q[i]};
            end
         end
         unique case (addr)
            mode_entry_pkg::GLOBAL_STATUS_OFS: begin
               rdata_d[mode_entry_pkg::GS_MODE_LSB +: 3] = mode_q;
               rdata_d[mode_entry_pkg::GS_FLASH_LSB +: 2] = fl.power;
               rdata_d[mode_entry_pkg::GS_MTRANS_BIT] = mtrans_q;
               rdata_d[mode_entry_pkg::GS_RAM_EXEC_BIT] = ram_q;
            end
            mode_entry_pkg::STOP_CFG_OFS: rdata_d[1:0] = stop_cfg_q;
            mode_entry_pkg::HALT_CFG_OFS: rdata_d[1:0] = halt_cfg_q;
            mode_entry_pkg::IRQ_STATUS_OFS: rdata_d[2:0] = ist_q;
            mode_entry_pkg::IRQ_ENABLE_OFS: rdata_d[2:0] = ien_q;
            default: ;
         endcase
      end
      ram_d = fl.power != mode_entry_pkg::FLASH_NORMAL;
      irq_d = |(ist_d & ien_d);
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= mode_entry_pkg::ST_RUN;
         mode_q <= mode_entry_pkg::MODE_RUN0;
         run_q <= mode_entry_pkg::MODE_RUN0;
         haz_q <= 2'h0;
         mtrans_q <= 1'b0;
         lp_cfg_q <= mode_entry_pkg::FLASH_CFG_RESET;
         for (int i = 0; i < mode_entry_pkg::RUN_MODES; i++) begin
            run_cfg_q[i] <= mode_entry_pkg::FLASH_CFG_RESET;
         end
         stop_cfg_q <= mode_entry_pkg::FLASH_CFG_RESET;
         halt_cfg_q <= mode_entry_pkg::FLASH_CFG_RESET;
         ist_q <= mode_entry_pkg::IRQ_RESET;
         ien_q <= mode_entry_pkg::IRQ_RESET;
         mchk_irq_q <= 1'b0;
         chkstop_q <= 1'b0;
         ram_q <= 1'b0;
         irq_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         st_q <= st_d;
         mode_q <= mode_d;
         run_q <= run_d;
         haz_q <= haz_d;
         mtrans_q <= mtrans_d;
         lp_cfg_q <= lp_cfg_d;
         run_cfg_q <= run_cfg_d;
         stop_cfg_q <= stop_cfg_d;
         halt_cfg_q <= halt_cfg_d;
         ist_q <= ist_d;
         ien_q <= ien_d;
         mchk_irq_q <= mchk_irq_d;
         chkstop_q <= chkstop_d;
         ram_q <= ram_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;
   assign machine_check_irq = mchk_irq_q;
   assign checkstop_reset = chkstop_q;
   assign exec_from_ram = ram_q;
   assign irq = irq_q;
endmodule

/* mode_entry_sva.sv */
`timescale 1ns/10ps
module mode_entry_sva (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [7:0] addr,
   input wire logic rd_stb,
   input wire logic [31:0] rdata,
   input wire logic wakeup,
   input wire logic code_in_flash,
   input wire logic core_machine_check_enable,
   input wire logic machine_check_irq,
   input wire logic checkstop_reset
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence chk_fired;
      machine_check_irq || checkstop_reset;
   endsequence
   sequence late_wake;
      $past(wakeup) && $past(code_in_flash);
   endsequence
   //////////////////////////////////////////////////////////////////////
   rd_idle_a: assert property (!rd_stb |=> rdata == 32'h0)
      else $error("read data not zero outside a read");
   unmapped_rd_a: assert property (
      rd_stb && addr >= 8'h2C |=> rdata == 32'h0)
      else $error("unmapped read returned data");
   mchk_cause_a: assert property (chk_fired |-> late_wake)
      else $error("machine check without wakeup from flash");
   mchk_en_a: assert property (
      machine_check_irq |-> $past(core_machine_check_enable))
      else $error("interrupt taken with enable clear");
   ckstop_en_a: assert property (
      checkstop_reset |-> !$past(core_machine_check_enable))
      else $error("checkstop taken with enable set");
   mchk_excl_a: assert property (
      !(machine_check_irq && checkstop_reset))
      else $error("both machine check outputs high");
   mchk_pulse_a: assert property (
      machine_check_irq |=> !machine_check_irq)
      else $error("machine check pulse too long");
   ckstop_pulse_a: assert property (
      checkstop_reset |=> !checkstop_reset)
      else $error("checkstop pulse too long");
endmodule

bind mode_entry_unit mode_entry_sva chk (
   .core_clk(core_clk),
   .arst_n(arst_n),
   .addr(addr),
   .rd_stb(rd_stb),
   .rdata(rdata),
   .wakeup(wakeup),
   .code_in_flash(code_in_flash),
   .core_machine_check_enable(core_machine_check_enable),
   .machine_check_irq(machine_check_irq),
   .checkstop_reset(checkstop_reset)
);

/* core_model.sv */
`timescale 1ns/10ps
module core_model (
   input wire logic wake_req,
   input wire logic run_in_flash,
   input wire logic mce_req,
   output logic wakeup,
   output logic code_in_flash,
   output logic core_machine_check_enable
);
   assign wakeup = wake_req;
   // software branches to ram before low-power entry when it can
   assign code_in_flash = run_in_flash;
   // handler lives in ram, so enable is raised before entry for recovery
   assign core_machine_check_enable = mce_req;
endmodule

/* tb_mode_entry_unit.sv */
`timescale 1ns/10ps
module tb_mode_entry_unit;
   logic core_clk, arst_n, wr_stb, rd_stb, wake_req, in_flash, mce;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic wakeup, code_in_flash, mce_o, mchk, ckstop, ram_exec, irq;
   int fail_count = 0, n_tests = 0, n_mchk = 0, n_ckstop = 0, cyc = 0;
   core_model core (.wake_req(wake_req), .run_in_flash(in_flash),
      .mce_req(mce), .wakeup(wakeup), .code_in_flash(code_in_flash),
      .core_machine_check_enable(mce_o));
   mode_entry_unit DUT (.core_clk(core_clk), .arst_n(arst_n), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .wakeup(wakeup), .code_in_flash(code_in_flash),
      .core_machine_check_enable(mce_o), .machine_check_irq(mchk),
      .checkstop_reset(ckstop), .exec_from_ram(ram_exec), .irq(irq));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // ceiling well above the few hundred cycles the tests need
   always @(posedge core_clk) begin
      cyc++;
      if (mchk === 1'b1) n_mchk++;
      if (ckstop === 1'b1) n_ckstop++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up;
      end
   end
   //////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask
   task wait_run;
      logic [31:0] s;
      repeat (4) @(posedge core_clk);
      repeat (40) begin
         rd(mode_entry_pkg::GLOBAL_STATUS_OFS, s);
         if (s[8] === 1'b0 && s[2:0] < 3'h4) break;
      end
   endtask
   task pulse_wake;
      @(posedge core_clk);
      wake_req <= 1'b1;
      @(posedge core_clk);
      wake_req <= 1'b0;
   endtask
   task do_reset;
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (12) @(posedge core_clk);
      arst_n <= 1'b1;
      n_mchk = 0;
      n_ckstop = 0;
   endtask
   //////////////////////////////////////////////////////////////////////
   task t_reset_vals;
      logic [31:0] s;
      rd(mode_entry_pkg::GLOBAL_STATUS_OFS, s);
      chk(s & 32'h337, 32'h30);
      rd(mode_entry_pkg::RUN_CFG_OFS, s);
      chk(s & 32'h3, 32'h3);
      rd(8'h40, s);
      chk(s, 32'h0);
   endtask
   // power-down, low-power, then normal so the run ends on flash
   task t_codes;
      logic [31:0] s, e;
      for (int c = 1; c < 4; c++) begin
         wr(mode_entry_pkg::RUN_CFG_OFS, c);
         wr(mode_entry_pkg::MODE_REQ_OFS, 32'h0);
         rd(mode_entry_pkg::GLOBAL_STATUS_OFS, s);
         chk(s & 32'h100, 32'h100);
         wait_run;
         e = 32'(c) << 4;
         e[9] = (c != 3);
         rd(mode_entry_pkg::GLOBAL_STATUS_OFS, s);
         chk(s & 32'h230, e);
         chk(32'(ram_exec), 32'(c != 3));
      end
      // an undefined mode code must leave the sequencer idle
      wr(mode_entry_pkg::MODE_REQ_OFS, 32'h6);
      rd(mode_entry_pkg::GLOBAL_STATUS_OFS, s);
      chk(s & 32'h107, 32'h0);
      wr(mode_entry_pkg::RUN_CFG_OFS + 8'h08, 32'h2);
      rd(mode_entry_pkg::RUN_CFG_OFS + 8'h08, s);
      chk(s, 32'h2);
      wr(mode_entry_pkg::MODE_REQ_OFS, 32'h2);
      wait_run;
      rd(mode_entry_pkg::GLOBAL_STATUS_OFS, s);
      chk(s & 32'h237, 32'h222);
      wr(mode_entry_pkg::MODE_REQ_OFS, 32'h0);
      wait_run;
      rd(mode_entry_pkg::GLOBAL_STATUS_OFS, s);
      chk(s & 32'h237, 32'h30);
   endtask
   task t_lp_exit;
      logic [31:0] s;
      // code stays in flash: a wakeup after the window must stay quiet
      in_flash <= 1'b1;
      for (int lp = 4; lp < 6; lp++) begin
         wr(mode_entry_pkg::RUN_CFG_OFS, 32'h2);
         wr(lp == 4 ? mode_entry_pkg::STOP_CFG_OFS :
            mode_entry_pkg::HALT_CFG_OFS, 32'h1);
         wr(mode_entry_pkg::MODE_REQ_OFS, lp);
         repeat (30) @(posedge core_clk);
         rd(mode_entry_pkg::GLOBAL_STATUS_OFS, s);
         chk(s & 32'h37, 32'h10 | lp);
         pulse_wake;
         wait_run;
         rd(mode_entry_pkg::GLOBAL_STATUS_OFS, s);
         chk(s & 32'h237, 32'h220);
         wr(mode_entry_pkg::RUN_CFG_OFS, 32'h3);
         wr(mode_entry_pkg::MODE_REQ_OFS, 32'h0);
         wait_run;
         rd(mode_entry_pkg::GLOBAL_STATUS_OFS, s);
         chk(s & 32'h237, 32'h30);
      end
      chk(n_mchk + n_ckstop, 0);
   endtask
   // wakeup lands inside the hazard window right after the stop request
   task t_mchk;
      logic [31:0] s;
      for (int en = 0; en < 2; en++) begin
         do_reset;
         mce <= en[0];
         in_flash <= 1'b1;
         wr(mode_entry_pkg::STOP_CFG_OFS, 32'h2);
         wr(mode_entry_pkg::MODE_REQ_OFS, 32'h4);
         pulse_wake;
         repeat (6) @(posedge core_clk);
         chk(n_mchk, en);
         chk(n_ckstop, 1 - en);
         rd(mode_entry_pkg::IRQ_STATUS_OFS, s);
         chk(s & 32'h2, 32'h2);
         chk(32'(irq), 32'h0);
         wr(mode_entry_pkg::IRQ_ENABLE_OFS, 32'h2);
         repeat (2) @(posedge core_clk);
         #1 chk(32'(irq), 32'h1);
         wr(mode_entry_pkg::IRQ_CLEAR_OFS, 32'h7);
         repeat (2) @(posedge core_clk);
         #1 chk(32'(irq), 32'h0);
         in_flash <= 1'b0;
         wr(mode_entry_pkg::MODE_REQ_OFS, 32'h0);
         wait_run;
         rd(mode_entry_pkg::GLOBAL_STATUS_OFS, s);
         chk(s & 32'h230, 32'h30);
      end
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   initial begin
      {arst_n, wr_stb, rd_stb, wake_req, in_flash, mce} = 6'h0;
      addr = 8'h0;
      wdata = 32'h0;
      repeat (12) @(posedge core_clk);
      arst_n <= 1'b1;
      t_reset_vals;
      t_codes;
      t_lp_exit;
      t_mchk;
      wrap_up;
   end
endmodule
